// ### hw/nvmac_cpu.sv
/*
 * cpu end: a small sequencer that performs byte reads and writes on
 * the io port using the safe software procedure.
 * assumes the device answers reads one cycle after io_rd.
 */
`timescale 1ns/1ns
module nvmac_cpu (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // io port to device
  nvmac_if.cpu bus,
  // user side
  input wire logic req,
  input wire logic req_write,
  input wire logic [8:0] req_addr,
  input wire logic [7:0] req_wdata,
  input wire logic selfprog_busy,
  output logic done,
  output logic [7:0] rd_data
);
  typedef enum logic [3:0] {
    S_IDLE, S_POLL, S_PWAIT, S_AL, S_AH, S_DATA, S_ARM, S_GO,
    S_STALL, S_RDREQ, S_RDGET, S_RDTAKE
  } nvmac_st_t;

  nvmac_st_t st_r;
  nvmac_st_t st_nxt;
  logic wr_r;
  logic [8:0] addr_r;
  logic [7:0] wdata_r;
  logic [7:0] rd_data_r;
  logic done_r;

  // ----------------------------------------------------------------
  // io drive
  // ----------------------------------------------------------------
  wire strobe_set = bus.io_rdata[nvmac_pkg::NVMAC_BIT_WR];
  wire [7:0] ctrl_arm = 8'(1 << nvmac_pkg::NVMAC_BIT_ARM);
  wire [7:0] ctrl_wr = 8'(1 << nvmac_pkg::NVMAC_BIT_WR);
  wire [7:0] ctrl_rd = 8'(1 << nvmac_pkg::NVMAC_BIT_RD);

  always_comb begin
    bus.io_addr = nvmac_pkg::NVMAC_OFS_CTRL;
    bus.io_wr = 1'b0;
    bus.io_rd = 1'b0;
    bus.io_wdata = 8'h00;
    st_nxt = st_r;
    case (st_r)
      S_IDLE: if (req) st_nxt = S_POLL;
      S_POLL: begin
        bus.io_rd = 1'b1;
        st_nxt = S_PWAIT;
      end
      // wait for strobe clear and flash idle first
      S_PWAIT: st_nxt = (strobe_set || selfprog_busy) ? S_POLL : S_AL;
      S_AL: begin
        bus.io_addr = nvmac_pkg::NVMAC_OFS_ADDRL;
        bus.io_wr = 1'b1;
        bus.io_wdata = addr_r[7:0];
        st_nxt = S_AH;
      end
      S_AH: begin
        bus.io_addr = nvmac_pkg::NVMAC_OFS_ADDRH;
        bus.io_wr = 1'b1;
        bus.io_wdata = {7'h00, addr_r[8]};
        st_nxt = wr_r ? S_DATA : S_RDREQ;
      end
      S_DATA: begin
        bus.io_addr = nvmac_pkg::NVMAC_OFS_DATA;
        bus.io_wr = 1'b1;
        bus.io_wdata = wdata_r;
        st_nxt = S_ARM;
      end
      S_ARM: begin
        bus.io_wr = 1'b1;
        bus.io_wdata = ctrl_arm;
        st_nxt = S_GO;
      end
      S_GO: begin
        bus.io_wr = 1'b1;
        bus.io_wdata = ctrl_wr;
        st_nxt = S_STALL;
      end
      S_RDREQ: begin
        bus.io_wr = 1'b1;
        bus.io_wdata = ctrl_rd;
        st_nxt = S_STALL;
      end
      S_STALL: if (!bus.stall) st_nxt = wr_r ? S_IDLE : S_RDGET;
      S_RDGET: begin
        bus.io_addr = nvmac_pkg::NVMAC_OFS_DATA;
        bus.io_rd = 1'b1;
        st_nxt = S_RDTAKE;
      end
      // the byte stands on io_rdata one cycle after io_rd
      S_RDTAKE: st_nxt = S_IDLE;
      default: st_nxt = S_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      st_r <= S_IDLE;
      wr_r <= 1'b0;
      addr_r <= 9'h000;
      wdata_r <= 8'h00;
    end else begin
      st_r <= st_nxt;
      if (st_r == S_IDLE && req) begin
        wr_r <= req_write;
        addr_r <= req_addr;
        wdata_r <= req_wdata;
      end
    end
  end

  // read byte lands one cycle after the data read is issued
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      done_r <= 1'b0;
      rd_data_r <= 8'h00;
    end else begin
      done_r <= (st_r == S_STALL && !bus.stall && wr_r) ||
                st_r == S_RDTAKE;
      if (st_r == S_RDTAKE) rd_data_r <= bus.io_rdata;
    end
  end

  assign done = done_r;
  assign rd_data = rd_data_r;
endmodule : nvmac_cpu

// ### hw/nvmac_dev.sv
/*
 * device end: io registers, arm window, cpu stall, self-timed write
 * counted on the rc oscillator tick, and the 512 byte array itself.
 * assumes rc_tick is a one-cycle pulse already on clk_sys and
 * selfprog_busy is a level from the flash logic on the same clock.
 * assumes the cpu issues nothing while stall is high and takes
 * io_rdata in the cycle after io_rd.
 */
`timescale 1ns/1ns
module nvmac_dev #(
  parameter int WR_RC_CYC = nvmac_pkg::NVMAC_WR_RC_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // cpu io port
  nvmac_if.dev bus,
  // system side
  input wire logic rc_tick,
  input wire logic selfprog_busy,
  output logic write_busy
);
  localparam int AW = nvmac_pkg::NVMAC_AW;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  // store and io registers
  logic [7:0] mem_r [nvmac_pkg::NVMAC_DEPTH];
  logic [AW-1:0] nvm_addr_reg_r;
  logic [7:0] nvm_data_reg_r;
  logic nvm_write_strobe_r;
  logic nvm_write_arm_r;
  // timers
  logic [2:0] arm_cnt_r;
  logic [2:0] stall_cnt_r;
  // 15 bits: a WR_RC_CYC above 32768 would wrap this counter
  logic [14:0] wr_cnt_r;
  // read port
  logic [7:0] rdata_r;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // io address compare, shared by the write decode and the read mux
  function automatic logic io_hit(input logic [5:0] addr,
                                  input logic [5:0] ofs);
    return addr == ofs;
  endfunction : io_hit

  // a down counter that still has cycles to run
  function automatic logic cnt_live(input logic [2:0] cnt);
    return cnt != 3'h0;
  endfunction : cnt_live

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire hit_ctrl = io_hit(bus.io_addr, nvmac_pkg::NVMAC_OFS_CTRL);
  wire hit_data = io_hit(bus.io_addr, nvmac_pkg::NVMAC_OFS_DATA);
  wire hit_al = io_hit(bus.io_addr, nvmac_pkg::NVMAC_OFS_ADDRL);
  wire hit_ah = io_hit(bus.io_addr, nvmac_pkg::NVMAC_OFS_ADDRH);

  wire wr_ctrl = bus.io_wr && hit_ctrl;
  wire wr_data = bus.io_wr && hit_data;
  wire wr_al = bus.io_wr && hit_al;
  wire wr_ah = bus.io_wr && hit_ah;

  wire bit_rd = bus.io_wdata[nvmac_pkg::NVMAC_BIT_RD];
  wire bit_wr = bus.io_wdata[nvmac_pkg::NVMAC_BIT_WR];
  wire bit_arm = bus.io_wdata[nvmac_pkg::NVMAC_BIT_ARM];

  // arm and strobe in one write arms nothing: the two-step order is
  // what keeps a stray byte from starting a write
  wire set_arm = wr_ctrl && bit_arm && !bit_wr;
  // strobe only takes while armed and no flash programming runs
  wire start_wr = wr_ctrl && bit_wr && nvm_write_arm_r &&
                  !nvm_write_strobe_r && !selfprog_busy;
  wire start_rd = wr_ctrl && bit_rd && !nvm_write_strobe_r;
  wire addr_open = !nvm_write_strobe_r;
  wire arm_expire = arm_cnt_r == 3'h1;
  wire wr_tick = nvm_write_strobe_r && rc_tick;
  wire wr_last = wr_cnt_r == 15'(WR_RC_CYC - 1);
  wire wr_done = wr_tick && wr_last;
  wire [2:0] stall_load = start_rd ? 3'(nvmac_pkg::NVMAC_RD_STALL) :
                          3'(nvmac_pkg::NVMAC_WR_STALL);

  // the read strobe reads back as zero: a read is over at once
  wire [7:0] ctrl_rd = (8'(nvm_write_arm_r) << nvmac_pkg::NVMAC_BIT_ARM) |
                       (8'(nvm_write_strobe_r) << nvmac_pkg::NVMAC_BIT_WR);
  wire [7:0] ah_rd = {{(16 - AW){1'b0}}, nvm_addr_reg_r[AW-1:8]};
  // unmapped offsets read as zero
  wire [7:0] rd_mux = hit_ctrl ? ctrl_rd :
                      hit_data ? nvm_data_reg_r :
                      hit_al ? nvm_addr_reg_r[7:0] :
                      hit_ah ? ah_rd : 8'h00;

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // stall decodes the counter, so the cpu sees it the cycle after the
  // strobe edge with no extra register in the way
  assign bus.stall = cnt_live(stall_cnt_r);
  assign bus.io_rdata = rdata_r;
  assign write_busy = nvm_write_strobe_r;

  // ----------------------------------------------------------------
  // write engine; ignores reset while a write runs so it survives it
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (start_wr) begin
      nvm_write_strobe_r <= 1'b1;
      wr_cnt_r <= 15'h0000;
    end else if (wr_done) begin
      nvm_write_strobe_r <= 1'b0;
    end else if (wr_tick) begin
      wr_cnt_r <= wr_cnt_r + 15'h0001;
    end
    // the case also clears an unknown power-up value, where a plain
    // test of the strobe would leave it unknown for good
    if (!rst_b) begin
      case (nvm_write_strobe_r)
        1'b1: ; // a running write carries on
        default: begin
          nvm_write_strobe_r <= 1'b0;
          wr_cnt_r <= 15'h0000;
        end
      endcase
    end
  end

  // the byte lands only when the timed write ends
  always_ff @(posedge clk_sys) begin
    if (wr_done) begin
      mem_r[nvm_addr_reg_r] <= nvm_data_reg_r;
    end
  end

  // ----------------------------------------------------------------
  // arm window
  // ----------------------------------------------------------------
  // the arm also drops on accept, so one arm buys at most one write
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      nvm_write_arm_r <= 1'b0;
      arm_cnt_r <= 3'h0;
    end else if (set_arm) begin
      nvm_write_arm_r <= 1'b1;
      arm_cnt_r <= 3'(nvmac_pkg::NVMAC_ARM_WIN);
    end else if (start_wr || arm_expire) begin
      nvm_write_arm_r <= 1'b0;
      arm_cnt_r <= 3'h0;
    end else if (cnt_live(arm_cnt_r)) begin
      arm_cnt_r <= arm_cnt_r - 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // cpu stall
  // ----------------------------------------------------------------
  // a new strobe reloads the counter; the cpu issues none while stalled
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      stall_cnt_r <= 3'h0;
    end else if (start_rd || start_wr) begin
      stall_cnt_r <= stall_load;
    end else if (cnt_live(stall_cnt_r)) begin
      stall_cnt_r <= stall_cnt_r - 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  // holds until the next io read, so a late sampler still sees it
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rdata_r <= 8'h00;
    end else if (bus.io_rd) begin
      rdata_r <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // data and address registers
  // ----------------------------------------------------------------
  // data and address are not reset: their start value is undefined
  always_ff @(posedge clk_sys) begin
    if (start_rd) begin
      nvm_data_reg_r <= mem_r[nvm_addr_reg_r];
    end else if (wr_data) begin
      nvm_data_reg_r <= bus.io_wdata;
    end
  end

  // address writes are dropped while a write runs, so the byte still
  // lands where it was aimed
  always_ff @(posedge clk_sys) begin
    if (wr_al && addr_open) begin
      nvm_addr_reg_r[7:0] <= bus.io_wdata;
    end
    if (wr_ah && addr_open) begin
      nvm_addr_reg_r[AW-1:8] <= bus.io_wdata[AW-9:0];
    end
  end
endmodule : nvmac_dev

// ### hw/nvmac_if.sv
/*
 * io register port between cpu core and the store controller.
 * assumes one shared clock; the cpu waits while stall is high.
 */
`timescale 1ns/1ns
interface nvmac_if;
  logic [5:0] io_addr;
  logic io_wr;
  logic io_rd;
  logic [7:0] io_wdata;
  logic [7:0] io_rdata;
  logic stall;

  modport dev (
    input io_addr,
    input io_wr,
    input io_rd,
    input io_wdata,
    output io_rdata,
    output stall
  );
  modport cpu (
    output io_addr,
    output io_wr,
    output io_rd,
    output io_wdata,
    input io_rdata,
    input stall
  );
endinterface : nvmac_if

// ### hw/nvmac_pkg.sv
/*
 * shared constants for the nonvolatile byte store access controller:
 * register offsets, control bit positions, stall and write timing.
 * assumes both ends include it and are built on one 100 MHz clock.
 */
package nvmac_pkg;
  // --------------------------------------------------------------
  // io space offsets
  // --------------------------------------------------------------
  localparam logic [5:0] NVMAC_OFS_CTRL = 6'h1F;
  localparam logic [5:0] NVMAC_OFS_DATA = 6'h20;
  localparam logic [5:0] NVMAC_OFS_ADDRL = 6'h21;
  localparam logic [5:0] NVMAC_OFS_ADDRH = 6'h22;
  // --------------------------------------------------------------
  // control register bits
  // --------------------------------------------------------------
  localparam int NVMAC_BIT_RD = 0;
  localparam int NVMAC_BIT_WR = 1;
  localparam int NVMAC_BIT_ARM = 2;
  // --------------------------------------------------------------
  // sizes and timing
  // --------------------------------------------------------------
  localparam int NVMAC_DEPTH = 512;
  localparam int NVMAC_AW = 9;
  localparam int NVMAC_ARM_WIN = 4;
  localparam int NVMAC_RD_STALL = 4;
  localparam int NVMAC_WR_STALL = 2;
  localparam int NVMAC_WR_RC_CYC = 27072;
endpackage : nvmac_pkg

// ### verification/nvmac_chk_sva.sv
/* io port checker for the store controller.
   assumes one clk_sys domain, rc_tick on it. */
`timescale 1ns/1ns
module nvmac_chk #(
  parameter int WR_RC_CYC = nvmac_pkg::NVMAC_WR_RC_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // io port
  input wire logic [5:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic stall,
  // device side
  input wire logic write_busy,
  input wire logic rc_tick,
  input wire logic selfprog_busy
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  wire ctl = io_addr == nvmac_pkg::NVMAC_OFS_CTRL;
  wire arm_wr = io_wr && ctl && io_wdata[2] && !io_wdata[1];
  wire strobe_wr = io_wr && ctl && io_wdata[1];
  wire rd_go = io_wr && ctl && io_wdata == 8'h01 && !stall;
  logic [3:0] age_r;
  logic [15:0] ticks_r;
  // age saturates so a stale arm never looks fresh
  always_ff @(posedge clk_sys) begin
    if (!rst_b) age_r <= 4'hF;
    else if (arm_wr) age_r <= 4'h1;
    else if (age_r != 4'hF) age_r <= age_r + 4'h1;
  end
  // no reset: a write runs on through reset
  always_ff @(posedge clk_sys) begin
    if (!write_busy) ticks_r <= 16'h0000;
    else if (rc_tick) ticks_r <= ticks_r + 16'h0001;
  end
  chk_rd_stall_len: assert property (rd_go && !write_busy |=>
    stall [*4] ##1 !stall) else $error("read stall length");
  chk_wr_stall_len: assert property ($rose(write_busy) |->
    stall [*2] ##1 !stall) else $error("write stall length");
  chk_arm_window: assert property ($rose(write_busy) |->
    $past(strobe_wr) && $past(age_r) >= 4'h1 && $past(age_r) <= 4'h4)
    else $error("write began outside arm window");
  chk_selfprog_lock: assert property ($rose(write_busy) |->
    !$past(selfprog_busy)) else $error("write during self-programming");
  chk_busy_no_read: assert property (rd_go && write_busy |=>
    !stall) else $error("read taken while busy");
  chk_ticks_max: assert property (write_busy |->
    ticks_r <= WR_RC_CYC) else $error("write ran too long");
  chk_ticks_end: assert property ($fell(write_busy) |->
    ticks_r == 16'(WR_RC_CYC)) else $error("write ended early");
  chk_addr_high: assert property (io_rd && io_addr ==
    nvmac_pkg::NVMAC_OFS_ADDRH |=> io_rdata[7:1] == 7'h00)
    else $error("unused address bits not zero");
  chk_arm_expire: assert property (io_rd && ctl && age_r >= 4'h6 |=>
    io_rdata[2] == 1'b0) else $error("arm bit did not expire");
  cover property ($rose(write_busy));
  cover property ($fell(write_busy));
  cover property (rd_go && !write_busy);
endmodule : nvmac_chk

// ### verification/tb.sv
/* bench: cpu end against device end, and a second device
   driven directly to break the access sequence. */
`timescale 1ns/1ns
module tb;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic rst2_b = 1'b0;
  logic rc_tick = 1'b0;
  logic [1:0] tick_cnt = 2'h0;
  logic sp_busy = 1'b0;
  logic sp2_busy = 1'b0;
  logic req = 1'b0;
  logic req_write = 1'b0;
  logic [8:0] req_addr = 9'h000;
  logic [7:0] req_wdata = 8'h00;
  logic done, wb, wb2;
  logic [7:0] rd_data, lf, d;
  logic [7:0] mem_m [512];
  logic [8:0] a_t [6];
  logic [8:0] exp_q [$];
  logic [8:0] e;
  int n_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  int i, k;
  nvmac_if ifc ();
  nvmac_if ifc2 ();
  nvmac_dev #(.WR_RC_CYC(8)) nvmac_dev_inst (.clk_sys(clk_sys),
    .rst_b(rst_b), .bus(ifc.dev), .rc_tick(rc_tick),
    .selfprog_busy(sp_busy), .write_busy(wb));
  nvmac_cpu nvmac_cpu_inst (.clk_sys(clk_sys), .rst_b(rst_b),
    .bus(ifc.cpu), .req(req), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .selfprog_busy(sp_busy), .done(done),
    .rd_data(rd_data));
  nvmac_dev #(.WR_RC_CYC(8)) nvmac_dev_b_inst (.clk_sys(clk_sys),
    .rst_b(rst2_b), .bus(ifc2.dev), .rc_tick(rc_tick),
    .selfprog_busy(sp2_busy), .write_busy(wb2));
  nvmac_chk #(.WR_RC_CYC(8)) nvmac_chk_inst (.clk_sys(clk_sys),
    .rst_b(rst_b), .io_addr(ifc.io_addr), .io_wr(ifc.io_wr),
    .io_rd(ifc.io_rd), .io_wdata(ifc.io_wdata), .io_rdata(ifc.io_rdata),
    .stall(ifc.stall), .write_busy(wb), .rc_tick(rc_tick),
    .selfprog_busy(sp_busy));
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  // rc tick every third cycle, unrelated to the request pattern
  always @(posedge clk_sys) begin
    tick_cnt <= (tick_cnt == 2'h2) ? 2'h0 : tick_cnt + 2'h1;
    rc_tick <= tick_cnt == 2'h2;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      conclude();
    end
  end
  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction : lfsr
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  task automatic op(input logic [5:0] a, input logic w,
    input logic [7:0] dv);
    @(posedge clk_sys);
    ifc2.io_addr <= a;
    ifc2.io_wr <= w;
    ifc2.io_rd <= !w;
    ifc2.io_wdata <= dv;
    @(posedge clk_sys);
    ifc2.io_wr <= 1'b0;
    ifc2.io_rd <= 1'b0;
    #1;
  endtask : op
  task automatic cpu_req(input logic w, input logic [8:0] a,
    input logic [7:0] dv);
    int n;
    exp_q.push_back({!w, w ? 8'h00 : mem_m[a]});
    if (w) mem_m[a] = dv;
    @(posedge clk_sys);
    req <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= dv;
    @(posedge clk_sys);
    req <= 1'b0;
    for (n = 0; n < 500 && done !== 1'b1; n++) @(posedge clk_sys);
  endtask : cpu_req
  always @(posedge clk_sys) begin
    if (done === 1'b1) begin
      if (exp_q.size() == 0) chk(8'hEE, 8'h00);
      else begin
        e = exp_q.pop_front();
        if (e[8]) chk(rd_data, e[7:0]);
      end
    end
  end
  initial begin
    lf = 8'h62;
    ifc2.io_addr = 6'h00;
    ifc2.io_wr = 1'b0;
    ifc2.io_rd = 1'b0;
    ifc2.io_wdata = 8'h00;
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    rst2_b <= 1'b1;
    for (i = 0; i < 6; i++) begin
      lf = lfsr(lf);
      a_t[i] = (i == 0) ? 9'h000 : (i == 1) ? 9'h1FF : {lf[0], lfsr(lf)};
      lf = lfsr(lf);
      cpu_req(1'b1, a_t[i], lf);
    end
    for (i = 5; i >= 0; i--) cpu_req(1'b0, a_t[i], 8'h00);
    sp_busy <= 1'b1;
    fork
      cpu_req(1'b1, 9'h005, 8'hA5);
    join_none
    repeat (20) @(posedge clk_sys);
    chk({7'h00, wb}, 8'h00);
    sp_busy <= 1'b0;
    wait fork;
    cpu_req(1'b0, 9'h005, 8'h00);
    $display("test cpu transfers done");
    d = lfsr(lf);
    op(nvmac_pkg::NVMAC_OFS_DATA, 1'b1, d);
    op(nvmac_pkg::NVMAC_OFS_ADDRL, 1'b1, 8'h3C);
    op(nvmac_pkg::NVMAC_OFS_ADDRH, 1'b1, 8'hFF);
    op(nvmac_pkg::NVMAC_OFS_CTRL, 1'b1, 8'h04);
    op(nvmac_pkg::NVMAC_OFS_CTRL, 1'b1, 8'h02);
    chk({7'h00, wb2}, 8'h01);
    op(nvmac_pkg::NVMAC_OFS_ADDRL, 1'b1, 8'h00);
    op(nvmac_pkg::NVMAC_OFS_CTRL, 1'b1, 8'h01);
    chk({7'h00, ifc2.stall}, 8'h00);
    rst2_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst2_b <= 1'b1;
    #1;
    chk({7'h00, wb2}, 8'h01);
    for (k = 0; k < 200 && wb2 === 1'b1; k++) @(posedge clk_sys);
    #1;
    chk({7'h00, wb2}, 8'h00);
    op(nvmac_pkg::NVMAC_OFS_DATA, 1'b1, ~d);
    op(nvmac_pkg::NVMAC_OFS_CTRL, 1'b1, 8'h01);
    repeat (6) @(posedge clk_sys);
    op(nvmac_pkg::NVMAC_OFS_DATA, 1'b0, 8'h00);
    chk(ifc2.io_rdata, d);
    op(nvmac_pkg::NVMAC_OFS_ADDRH, 1'b0, 8'h00);
    chk(ifc2.io_rdata, 8'h01);
    $display("test direct write done");
    op(nvmac_pkg::NVMAC_OFS_CTRL, 1'b1, 8'h04);
    repeat (4) @(posedge clk_sys);
    op(nvmac_pkg::NVMAC_OFS_CTRL, 1'b1, 8'h02);
    chk({7'h00, wb2}, 8'h00);
    op(nvmac_pkg::NVMAC_OFS_CTRL, 1'b0, 8'h00);
    chk(ifc2.io_rdata, 8'h00);
    sp2_busy <= 1'b1;
    op(nvmac_pkg::NVMAC_OFS_CTRL, 1'b1, 8'h04);
    op(nvmac_pkg::NVMAC_OFS_CTRL, 1'b1, 8'h02);
    chk({7'h00, wb2}, 8'h00);
    sp2_busy <= 1'b0;
    $display("test refused writes done");
    conclude();
  end
endmodule : tb
